// ### hw/earth_fault_phase_selector.sv
// earth-fault phase selector: start gating, per-phase comparators, registers
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module earth_fault_phase_selector
   import phase_sel_pkg::*;
#(
   parameter int MAG_W = 16,
   parameter logic [MAG_W-1:0] RATED_MAG = 16'h2710,
   parameter int DROP_CYCLES = RESET_CYCLES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic earthFaultStartIn,
   input wire logic vtSupervisionBlockIn,
   input wire logic [MAG_W-1:0] phase1VoltageMagnitude,
   input wire logic [MAG_W-1:0] phase2VoltageMagnitude,
   input wire logic [MAG_W-1:0] phase3VoltageMagnitude,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [DATA_W-1:0] regRdData,
   output logic phase1FaultFlag,
   output logic phase2FaultFlag,
   output logic phase3FaultFlag,
   output logic irq
);

   sel_state_t state_q;
   sel_state_t state_d;
   logic evalEn;
   logic [MAG_W-1:0] magnitude [NUM_PHASES];
   logic [NUM_PHASES-1:0] faultFlag;
   logic [NUM_PHASES-1:0] faultFlagPrev_q;
   logic [NUM_PHASES-1:0] flagRise;
   logic [NUM_PHASES-1:0] capture_q;
   logic [COUNT_W-1:0] pickCount_q [NUM_PHASES];
   logic [THR_W-1:0] startVoltageThreshold_q;
   logic [THR_W-1:0] thrWrValue;
   logic thrWrInRange;
   logic thrWr;
   logic thrReject;
   logic [EVT_W-1:0] evtSet;
   logic [EVT_W-1:0] evtStatus;
   logic [EVT_W-1:0] evtEnable;
   logic clrWr;
   logic enWr;
   logic [NUM_PHASES-1:0] countWr;
   logic [DATA_W-1:0] readWord;
   logic [DATA_W-1:0] regRdData_q;

   assign magnitude[0] = phase1VoltageMagnitude;
   assign magnitude[1] = phase2VoltageMagnitude;
   assign magnitude[2] = phase3VoltageMagnitude;

   // evaluation sequence; blocking always takes priority over start
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (vtSupervisionBlockIn) begin
               state_d = ST_BLOCKED;
            end else if (earthFaultStartIn) begin
               state_d = ST_EVAL;
            end
         end
         ST_EVAL: begin
            if (vtSupervisionBlockIn) begin
               state_d = ST_BLOCKED;
            end else if (!earthFaultStartIn) begin
               state_d = ST_IDLE;
            end
         end
         ST_BLOCKED: begin
            // leave through idle so a held start re-enters cleanly
            if (!vtSupervisionBlockIn) begin
               state_d = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   assign evalEn = (state_q == ST_EVAL) && earthFaultStartIn && !vtSupervisionBlockIn;

   genvar ph;
   generate
      for (ph = 0; ph < NUM_PHASES; ph++) begin : g_phase
         undervoltage_comparator #(
            .MAG_W(MAG_W),
            .RATED_MAG(RATED_MAG),
            .DROP_CYCLES(DROP_CYCLES)
         ) u_cmp (
            .mclk(mclk),
            .rst(rst),
            .evalEn(evalEn),
            .magnitude(magnitude[ph]),
            .threshold(startVoltageThreshold_q),
            .faultFlag(faultFlag[ph])
         );

         // pickups per phase, saturating, cleared by a write to that phase's count register
         always_ff @(posedge mclk) begin
            if (rst || countWr[ph]) begin
               pickCount_q[ph] <= '0;
            end else if (flagRise[ph] && (pickCount_q[ph] != '1)) begin
               pickCount_q[ph] <= pickCount_q[ph] + 1'b1;
            end
         end
      end
   endgenerate

   assign phase1FaultFlag = faultFlag[0];
   assign phase2FaultFlag = faultFlag[1];
   assign phase3FaultFlag = faultFlag[2];

   always_ff @(posedge mclk) begin
      if (rst) begin
         faultFlagPrev_q <= '0;
      end else begin
         faultFlagPrev_q <= faultFlag;
      end
   end

   assign flagRise = faultFlag & ~faultFlagPrev_q;

   // phases selected during the current start; kept after it ends
   always_ff @(posedge mclk) begin
      if (rst) begin
         capture_q <= '0;
      end else if ((state_q != ST_EVAL) && (state_d == ST_EVAL)) begin
         capture_q <= '0;
      end else begin
         capture_q <= capture_q | faultFlag;
      end
   end

   // register write decode
   assign thrWr = regWr && (regAddr == ADDR_THRESHOLD);
   assign clrWr = regWr && (regAddr == ADDR_CLEAR);
   assign enWr = regWr && (regAddr == ADDR_ENABLE);
   assign countWr[0] = regWr && (regAddr == ADDR_COUNT1);
   assign countWr[1] = regWr && (regAddr == ADDR_COUNT2);
   assign countWr[2] = regWr && (regAddr == ADDR_COUNT3);

   assign thrWrValue = regWrData[THR_W-1:0];
   assign thrWrInRange = (regWrData[DATA_W-1:THR_W] == '0) && (thrWrValue >= THR_MIN)
      && (thrWrValue <= THR_MAX);
   assign thrReject = thrWr && !thrWrInRange;

   always_ff @(posedge mclk) begin
      if (rst) begin
         startVoltageThreshold_q <= THR_RESET;
      end else if (thrWr && thrWrInRange) begin
         startVoltageThreshold_q <= thrWrValue;
      end
   end

   // of the comparator settings only the threshold is writable
   // ratio, scale and drop-out time are constants of the comparator

   assign evtSet = {thrReject, flagRise};

   event_status #(
      .N(EVT_W)
   ) u_evt (
      .mclk(mclk),
      .rst(rst),
      .setEvt(evtSet),
      .clrWr(clrWr),
      .clrMask(regWrData[EVT_W-1:0]),
      .enWr(enWr),
      .enData(regWrData[EVT_W-1:0]),
      .status(evtStatus),
      .enable(evtEnable),
      .irq(irq)
   );

   // read mux; unmapped and write-only addresses read zero
   always_comb begin
      readWord = '0;
      unique case (regAddr)
         ADDR_THRESHOLD: readWord[THR_W-1:0] = startVoltageThreshold_q;
         ADDR_LIVE: begin
            readWord[NUM_PHASES-1:0] = faultFlag;
            readWord[LIVE_START_BIT] = earthFaultStartIn;
            readWord[LIVE_BLOCK_BIT] = vtSupervisionBlockIn;
            readWord[LIVE_STATE_LSB +: 3] = state_q;
         end
         ADDR_STATUS: readWord[EVT_W-1:0] = evtStatus;
         ADDR_ENABLE: readWord[EVT_W-1:0] = evtEnable;
         ADDR_COUNT1: readWord[COUNT_W-1:0] = pickCount_q[0];
         ADDR_COUNT2: readWord[COUNT_W-1:0] = pickCount_q[1];
         ADDR_COUNT3: readWord[COUNT_W-1:0] = pickCount_q[2];
         ADDR_CAPTURE: readWord[NUM_PHASES-1:0] = capture_q;
         default: readWord = '0;
      endcase
   end

   // data stand only in the cycle after the read strobe
   always_ff @(posedge mclk) begin
      if (rst) begin
         regRdData_q <= '0;
      end else if (regRd) begin
         regRdData_q <= readWord;
      end else begin
         regRdData_q <= '0;
      end
   end

   assign regRdData = regRdData_q;

endmodule

// ### hw/event_status.sv
// sticky event status with clear, enable and a level interrupt
`timescale 1ns/100ps
module event_status #(
   parameter int N = 4
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [N-1:0] setEvt,
   input wire logic clrWr,
   input wire logic [N-1:0] clrMask,
   input wire logic enWr,
   input wire logic [N-1:0] enData,
   output logic [N-1:0] status,
   output logic [N-1:0] enable,
   output logic irq
);
   logic [N-1:0] status_q;
   logic [N-1:0] status_d;
   logic [N-1:0] enable_q;
   logic [N-1:0] enable_d;
   logic irq_q;

   // set wins over a clear in the same cycle
   always_comb begin
      status_d = (status_q & ~(clrWr ? clrMask : '0)) | setEvt;
      enable_d = enWr ? enData : enable_q;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         status_q <= '0;
      end else begin
         status_q <= status_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         enable_q <= '0;
      end else begin
         enable_q <= enable_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_d & enable_d);
      end
   end

   assign status = status_q;
   assign enable = enable_q;
   assign irq = irq_q;
endmodule

// ### hw/phase_sel_pkg.sv
// constants, register map and types of the earth-fault phase selector
package phase_sel_pkg;

   // clock and drop-out timing
   localparam int CLK_FREQ_HZ = 125_000_000;
   localparam int RESET_TIME_MS = 50;
   localparam int RESET_CYCLES = CLK_FREQ_HZ / 1000 * RESET_TIME_MS;

   // start-voltage threshold in percent of rated voltage
   localparam int THR_W = 6;
   localparam logic [5:0] THR_MIN = 6'h05;
   localparam logic [5:0] THR_MAX = 6'h39;
   localparam logic [5:0] THR_RESET = 6'h2d;

   // fixed comparator constants, not reachable by software
   localparam int PCT_SCALE = 100;
   localparam int RESET_RATIO_NUM = 105;
   localparam int RESET_RATIO_DEN = 100;

   // register bus
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] ADDR_THRESHOLD = 8'h00;
   localparam logic [7:0] ADDR_LIVE = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_CLEAR = 8'h0c;
   localparam logic [7:0] ADDR_ENABLE = 8'h10;
   localparam logic [7:0] ADDR_COUNT1 = 8'h14;
   localparam logic [7:0] ADDR_COUNT2 = 8'h18;
   localparam logic [7:0] ADDR_COUNT3 = 8'h1c;
   localparam logic [7:0] ADDR_CAPTURE = 8'h20;

   // field positions
   localparam int NUM_PHASES = 3;
   localparam int LIVE_START_BIT = 3;
   localparam int LIVE_BLOCK_BIT = 4;
   localparam int LIVE_STATE_LSB = 5;
   localparam int EVT_REJECT_BIT = 3;
   localparam int EVT_W = 4;
   localparam int COUNT_W = 16;

   // evaluation sequence
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EVAL = 3'b010,
      ST_BLOCKED = 3'b100
   } sel_state_t;

endpackage

// ### hw/undervoltage_comparator.sv
// one phase undervoltage comparator with reset hysteresis and drop-out delay
`timescale 1ns/100ps
module undervoltage_comparator
   import phase_sel_pkg::*;
#(
   parameter int MAG_W = 16,
   parameter logic [MAG_W-1:0] RATED_MAG = 16'h2710,
   parameter int DROP_CYCLES = RESET_CYCLES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic evalEn,
   input wire logic [MAG_W-1:0] magnitude,
   input wire logic [THR_W-1:0] threshold,
   output logic faultFlag
);
   localparam int PROD_W = MAG_W + 24;
   localparam int CNT_W = $clog2(DROP_CYCLES + 1);

   logic [PROD_W-1:0] magScaled;
   logic [PROD_W-1:0] pickLevel;
   logic [PROD_W-1:0] magHys;
   logic [PROD_W-1:0] dropLevel;
   logic belowPick;
   logic recovered;
   logic faultFlag_q;
   logic [CNT_W-1:0] dropCnt_q;

   // percentages compared by cross multiplication, no divider needed
   assign magScaled = PROD_W'(magnitude) * PROD_W'(PCT_SCALE);
   assign pickLevel = PROD_W'(threshold) * PROD_W'(RATED_MAG);
   assign magHys = magScaled * PROD_W'(RESET_RATIO_DEN);
   assign dropLevel = pickLevel * PROD_W'(RESET_RATIO_NUM);
   assign belowPick = magScaled < pickLevel;
   assign recovered = magHys > dropLevel;

   always_ff @(posedge mclk) begin
      if (rst || !evalEn) begin
         faultFlag_q <= 1'b0;
         dropCnt_q <= '0;
      end else if (!faultFlag_q) begin
         faultFlag_q <= belowPick;
         dropCnt_q <= '0;
      end else if (recovered) begin
         if (dropCnt_q == CNT_W'(DROP_CYCLES - 1)) begin
            faultFlag_q <= 1'b0;
            dropCnt_q <= '0;
         end else begin
            dropCnt_q <= dropCnt_q + 1'b1;
         end
      end else begin
         dropCnt_q <= '0;
      end
   end

   assign faultFlag = faultFlag_q;
endmodule

// ### tb/far_side_model.sv
// residual protection, vt supervision and magnitude stage model
`timescale 1ns/100ps
module far_side_model (
   input wire logic mclk,
   input wire logic tripReq,
   input wire logic vtFail,
   input wire logic [6:0] pct1,
   input wire logic [6:0] pct2,
   input wire logic [6:0] pct3,
   output logic earthFaultStartIn,
   output logic vtSupervisionBlockIn,
   output logic [15:0] phase1VoltageMagnitude,
   output logic [15:0] phase2VoltageMagnitude,
   output logic [15:0] phase3VoltageMagnitude
);
   // start and block outputs registered, so the selector sees one cycle of wiring delay; magnitudes follow pct at once
   initial {earthFaultStartIn, vtSupervisionBlockIn} = 2'b00;
   always @(posedge mclk) begin
      earthFaultStartIn <= tripReq;
      vtSupervisionBlockIn <= vtFail;
   end
   always @(pct1, pct2, pct3) begin
      phase1VoltageMagnitude = 16'(pct1 * 100);
      phase2VoltageMagnitude = 16'(pct2 * 100);
      phase3VoltageMagnitude = 16'(pct3 * 100);
   end
endmodule

// ### tb/phase_sel_monitor.sv
// port checker for the earth-fault phase selector
`timescale 1ns/100ps
module phase_sel_monitor
   import phase_sel_pkg::*;
#(
   parameter int MAG_W = 16,
   parameter logic [MAG_W-1:0] RATED_MAG = 16'h2710,
   parameter int DROP_CYCLES = RESET_CYCLES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic earthFaultStartIn,
   input wire logic vtSupervisionBlockIn,
   input wire logic [MAG_W-1:0] phase1VoltageMagnitude,
   input wire logic [MAG_W-1:0] phase2VoltageMagnitude,
   input wire logic [MAG_W-1:0] phase3VoltageMagnitude,
   input wire logic regRd,
   input wire logic [DATA_W-1:0] regRdData,
   input wire logic phase1FaultFlag,
   input wire logic phase2FaultFlag,
   input wire logic phase3FaultFlag,
   input wire logic irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // above max threshold times hysteresis
   localparam int HI = int'(RATED_MAG) * 60 / 100;
   localparam int LO = int'(RATED_MAG) * 57 / 100;
   logic [15:0] hiCnt_q;
   always_ff @(posedge mclk) begin
      if (rst || int'(phase1VoltageMagnitude) < HI) hiCnt_q <= 16'h0;
      else if (hiCnt_q != 16'hffff) hiCnt_q <= hiCnt_q + 16'h1;
   end
   wire logic ok = earthFaultStartIn && !vtSupervisionBlockIn;
   chk_start_gates_flag:
      assert property (!earthFaultStartIn |=> !phase1FaultFlag) else $error("flag1 without start");
   chk_block_clears_flag:
      assert property (vtSupervisionBlockIn |=> !phase2FaultFlag) else $error("flag2 while blocked");
   chk_pickup_phase1:
      assert property ((ok && phase1VoltageMagnitude == '0)[*4] |-> phase1FaultFlag) else $error("flag1 late");
   chk_pickup_phase3:
      assert property ((ok && phase3VoltageMagnitude == '0)[*4] |-> phase3FaultFlag) else $error("flag3 late");
   chk_rise_needs_start:
      assert property ($rose(phase1FaultFlag) |-> $past(ok)) else $error("flag1 rose ungated");
   chk_rise_needs_dip:
      assert property ($rose(phase2FaultFlag) |-> int'($past(phase2VoltageMagnitude)) < LO)
         else $error("flag2 rose at high voltage");
   chk_hold_on_dip:
      assert property (phase1FaultFlag && ok && phase1VoltageMagnitude == '0 |=> phase1FaultFlag)
         else $error("flag1 dropped early");
   chk_drop_not_early:
      assert property ($fell(phase1FaultFlag) && $past(ok) |-> int'(hiCnt_q) >= DROP_CYCLES)
         else $error("flag1 recovery too short");
   chk_drop_bounded:
      assert property (int'(hiCnt_q) > DROP_CYCLES |-> !phase1FaultFlag) else $error("flag1 recovery too long");
   chk_read_idle_zero:
      assert property (!$past(regRd) |-> regRdData == '0) else $error("read data outside slot");
   cover property ($rose(phase1FaultFlag));
   cover property ($rose(irq));
   cover property (phase1FaultFlag && phase2FaultFlag && phase3FaultFlag);
endmodule

bind earth_fault_phase_selector phase_sel_monitor #(.MAG_W(MAG_W), .RATED_MAG(RATED_MAG),
   .DROP_CYCLES(DROP_CYCLES)) mon (.mclk, .rst, .earthFaultStartIn, .vtSupervisionBlockIn,
   .phase1VoltageMagnitude, .phase2VoltageMagnitude, .phase3VoltageMagnitude, .regRd, .regRdData,
   .phase1FaultFlag, .phase2FaultFlag, .phase3FaultFlag, .irq);

// ### tb/testbench.sv
// self-checking bench for the earth-fault phase selector
`timescale 1ns/100ps
module testbench;
   import phase_sel_pkg::*;
   localparam int DROP = 8;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic tripReq = 1'b0;
   logic vtFail = 1'b0;
   logic [6:0] pct1 = 7'h64;
   logic [6:0] pct2 = 7'h64;
   logic [6:0] pct3 = 7'h64;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic start, blk, irq;
   logic [15:0] mag1, mag2, mag3;
   logic [31:0] regRdData;
   wire logic [2:0] flags;
   int mismatches = 0;
   int samples_checked = 0;
   far_side_model fs (.mclk(mclk), .tripReq(tripReq), .vtFail(vtFail), .pct1(pct1), .pct2(pct2),
      .pct3(pct3), .earthFaultStartIn(start), .vtSupervisionBlockIn(blk), .phase1VoltageMagnitude(mag1),
      .phase2VoltageMagnitude(mag2), .phase3VoltageMagnitude(mag3));
   earth_fault_phase_selector #(.DROP_CYCLES(DROP)) dut (.mclk(mclk), .rst(rst), .earthFaultStartIn(start),
      .vtSupervisionBlockIn(blk), .phase1VoltageMagnitude(mag1), .phase2VoltageMagnitude(mag2),
      .phase3VoltageMagnitude(mag3), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .phase1FaultFlag(flags[0]), .phase2FaultFlag(flags[1]),
      .phase3FaultFlag(flags[2]), .irq(irq));
   initial begin
      forever #4 mclk = ~mclk;
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic fl(input logic [2:0] e, input string what);
      chk(what, 32'(e), 32'(flags));
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string what);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      chk(what, e, regRdData);
   endtask
   task automatic drv(input logic t, input logic b, input logic [6:0] a, input logic [6:0] c,
      input logic [6:0] d);
      @(posedge mclk);
      tripReq <= t;
      vtFail <= b;
      pct1 <= a;
      pct2 <= c;
      pct3 <= d;
   endtask
   task automatic t_regs;
      rc(ADDR_THRESHOLD, 32'h2d, "thr reset");
      rc(8'h40, 32'h0, "unmapped");
      wr(ADDR_THRESHOLD, 32'h4);
      rc(ADDR_THRESHOLD, 32'h2d, "thr below min");
      wr(ADDR_THRESHOLD, 32'h3a);
      rc(ADDR_THRESHOLD, 32'h2d, "thr above max");
      rc(ADDR_STATUS, 32'h8, "reject status");
      wr(ADDR_THRESHOLD, 32'h5);
      rc(ADDR_THRESHOLD, 32'h5, "thr min");
      wr(ADDR_THRESHOLD, 32'h39);
      rc(ADDR_THRESHOLD, 32'h39, "thr max");
      drv(1'b1, 1'b0, 7'd56, 7'd57, 7'd100);
      cyc(5);
      fl(3'b001, "flags at thr 57");
      drv(1'b0, 1'b0, 7'd56, 7'd57, 7'd100);
      cyc(3);
      fl(3'b000, "flags after withdraw");
      wr(ADDR_THRESHOLD, 32'h2d);
      $display("test regs done");
   endtask
   task automatic t_pickup;
      cyc(5);
      fl(3'b000, "flags low no start");
      // phase 2 sits exactly on the threshold: strict compare
      drv(1'b1, 1'b0, 7'd40, 7'd45, 7'd100);
      cyc(5);
      fl(3'b001, "one phase low");
      drv(1'b1, 1'b0, 7'd0, 7'd44, 7'd0);
      cyc(4);
      fl(3'b111, "all phases low");
      drv(1'b1, 1'b1, 7'd0, 7'd44, 7'd0);
      cyc(3);
      fl(3'b000, "blocked clears");
      cyc(5);
      fl(3'b000, "blocked stays low");
      drv(1'b1, 1'b0, 7'd0, 7'd44, 7'd0);
      cyc(6);
      fl(3'b111, "unblocked picks up");
      drv(1'b0, 1'b0, 7'd0, 7'd44, 7'd0);
      cyc(3);
      fl(3'b000, "withdraw clears");
      $display("test pickup done");
   endtask
   task automatic t_drop;
      drv(1'b1, 1'b0, 7'd10, 7'd100, 7'd100);
      cyc(5);
      fl(3'b001, "dip flagged");
      // inside the hysteresis band the flag must hold
      drv(1'b1, 1'b0, 7'd47, 7'd100, 7'd100);
      cyc(DROP + 4);
      fl(3'b001, "hysteresis holds");
      drv(1'b1, 1'b0, 7'd100, 7'd100, 7'd100);
      cyc(DROP - 1);
      fl(3'b001, "drop delay running");
      cyc(4);
      fl(3'b000, "drop delay over");
      drv(1'b0, 1'b0, 7'd100, 7'd100, 7'd100);
      $display("test drop done");
   endtask
   task automatic t_irq;
      wr(ADDR_CLEAR, 32'hf);
      rc(ADDR_STATUS, 32'h0, "status cleared");
      wr(ADDR_ENABLE, 32'h1);
      rc(ADDR_ENABLE, 32'h1, "enable readback");
      wr(ADDR_COUNT1, 32'h0);
      wr(ADDR_COUNT2, 32'h0);
      rc(ADDR_COUNT2, 32'h0, "count2 cleared");
      drv(1'b1, 1'b0, 7'd100, 7'd20, 7'd100);
      cyc(5);
      chk("irq masked", 32'h0, 32'(irq));
      drv(1'b1, 1'b0, 7'd20, 7'd20, 7'd100);
      cyc(5);
      rc(ADDR_STATUS, 32'h3, "status sticky");
      chk("irq raised", 32'h1, 32'(irq));
      // flags 011, start high, state eval
      rc(ADDR_LIVE, 32'h4b, "live word");
      rc(ADDR_CAPTURE, 32'h3, "capture");
      rc(ADDR_COUNT1, 32'h1, "count1");
      rc(ADDR_COUNT2, 32'h1, "count2");
      wr(ADDR_CLEAR, 32'h3);
      cyc(2);
      chk("irq cleared", 32'h0, 32'(irq));
      drv(1'b0, 1'b0, 7'd100, 7'd100, 7'd100);
      $display("test irq done");
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      t_regs;
      t_pickup;
      t_drop;
      t_irq;
      wrap_up;
   end
   initial begin
      repeat (3000) @(posedge mclk);
      mismatches++;
      wrap_up;
   end
endmodule
